//--- verilog/qct_pkg.sv
// Shared constants, register map and carrier types of the quad counter/timer.
// Assumes one 20 MHz device clock and a host on a plain strobe register port.
package qct_pkg;

    // =========================================================
    // Sizes and register map
    localparam int          CH_COUNT      = 4;
    localparam int          DATA_W        = 16;
    localparam int          ADDR_W        = 5;
    localparam int          PRE_W         = DATA_W + 2;
    localparam logic [4:0]  CMD_BASE      = 5'h00;
    localparam logic [4:0]  IMAGE_BASE    = 5'h04;
    localparam logic [4:0]  COUNT_BASE    = 5'h08;
    localparam logic [4:0]  GLOBAL_OFF    = 5'h0C;
    localparam logic [4:0]  LOADSTORE_OFF = 5'h0D;
    localparam logic [4:0]  FREEZE_OFF    = 5'h0E;
    localparam logic [4:0]  STATUS_OFF    = 5'h0F;
    localparam logic [4:0]  DELAY_OFF     = 5'h10;
    localparam logic [4:0]  POWER_OFF     = 5'h11;

    // =========================================================
    // Field positions, codes and reset values
    localparam int          FAMILY_BIT    = 0;
    localparam int          TMRCLK_BIT    = 7;
    localparam logic [2:0]  MODE_WAVE     = 3'h0;
    localparam logic [2:0]  MODE_PULSE    = 3'h1;
    localparam logic [2:0]  MODE_EVENT    = 3'h2;
    localparam logic [2:0]  MODE_CAPTURE  = 3'h3;
    localparam logic [2:0]  MODE_WATCHDOG = 3'h4;
    localparam logic [8:0]  CMD_RESET     = 9'h000;
    localparam logic [15:0] DELAY_RESET   = 16'h0000;

    // =========================================================
    // Timing
    localparam int CLOCK_HZ        = 20_000_000;
    localparam int MAX_INPUT_HZ    = 30_000_000;
    localparam int MAX_COUNT_HZ    = 7_000_000;
    localparam int MIN_TICK_NS     = 143;
    localparam int BASE_DIV        = 4;
    localparam int CLOCK_NS        = 1_000_000_000 / CLOCK_HZ;
    localparam int MIN_TICK_CYCLES = (MIN_TICK_NS + CLOCK_NS - 1) / CLOCK_NS;

    // =========================================================
    // Types
    typedef struct packed {
        logic       run;
        logic       srcArray;
        logic       srcPin;
        logic       countUp;
        logic       inPol;
        logic       outPol;
        logic [2:0] mode;
    } qct_cfg_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } qct_req_type;

    typedef enum logic [2:0] {
        MD_OFF, MD_WAVE, MD_PULSE, MD_EVENT, MD_CAPTURE, MD_WATCHDOG
    } qct_mode_type;

endpackage : qct_pkg

//--- verilog/qct_unit.sv
// One count unit: up/down counter with its image register and mode logic.
// Assumes one-cycle tick, trigger and write strobes from the same clock.
`timescale 1ns/1ps
module qct_unit #(
    parameter int DATA_W = qct_pkg::DATA_W
) (
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire logic                  tick,
    input  wire qct_pkg::qct_mode_type mode,
    input  wire qct_pkg::qct_cfg_type  cfg,
    input  wire logic                  trigger,
    input  wire logic                  swStrobe,
    input  wire logic                  handIn,
    input  wire logic                  freeze,
    input  wire logic                  imageWrite,
    input  wire logic                  countWrite,
    input  wire logic [DATA_W-1:0]     wdata,
    output logic      [DATA_W-1:0]     count,
    output logic      [DATA_W-1:0]     image,
    output logic                       tcPulse,
    output logic                       irq,
    output logic                       outLevel,
    output logic                       freezeAck,
    output logic                       active
);
    logic [DATA_W-1:0] next_count;
    logic [DATA_W-1:0] next_image;
    logic              next_tcPulse;
    logic              next_irq;
    logic              next_outLevel;
    logic              next_active;
    logic              bark;
    logic              next_bark;
    logic              pend;
    logic              next_pend;
    logic              up;
    logic              wrap;
    logic              step;
    logic              loadGo;
    logic              storeGo;

    // =========================================================
    // Counting, loading and capture
    always_comb
    begin
        next_count    = count;
        next_image    = image;
        next_active   = active;
        next_bark     = bark;
        next_pend     = pend;
        next_tcPulse  = 1'b0;
        loadGo        = 1'b0;
        storeGo       = 1'b0;
        step          = 1'b0;
        up = cfg.countUp && (mode != qct_pkg::MD_WATCHDOG);
        wrap = up ? (count == 16'hFFFF) : (count == 16'h0000);
        case (mode)
            qct_pkg::MD_WAVE:
            begin
                step   = cfg.run && active;
                loadGo = trigger || swStrobe || handIn;
            end
            qct_pkg::MD_PULSE, qct_pkg::MD_WATCHDOG:
            begin
                step   = cfg.run && active;
                loadGo = trigger || swStrobe;
            end
            qct_pkg::MD_EVENT:
            begin
                step = cfg.run && pend;
            end
            qct_pkg::MD_CAPTURE:
            begin
                step    = cfg.run;
                storeGo = trigger || swStrobe;
            end
            default:
            begin
                next_active = 1'b0;
            end
        endcase
        if (tick)
        begin
            next_pend = 1'b0;
        end
        if (tick && step)
        begin
            next_count = up ? count + 16'h0001 : count - 16'h0001;
            if (wrap)
            begin
                next_tcPulse = 1'b1;
                next_active  = 1'b0;
                next_bark    = (mode == qct_pkg::MD_WATCHDOG);
            end
        end
        // A trigger in the tick cycle stays pending for the next tick.
        if (trigger && mode == qct_pkg::MD_EVENT)
        begin
            next_pend = 1'b1;
        end
        if (loadGo)
        begin
            next_count  = image;
            next_active = 1'b1;
            next_bark   = 1'b0;
        end
        if (countWrite)
        begin
            next_count = wdata;
        end
        // Freeze holds the image still for the host while counting goes on.
        if (!freeze && mode == qct_pkg::MD_EVENT)
        begin
            next_image = next_count;
        end
        if (!freeze && storeGo)
        begin
            next_image = count;
        end
        if (imageWrite)
        begin
            next_image = wdata;
        end
        next_irq = next_tcPulse || storeGo;
        if (mode == qct_pkg::MD_WATCHDOG)
        begin
            next_outLevel = next_bark ? cfg.outPol : !cfg.outPol;
        end
        else
        begin
            next_outLevel = next_active ? cfg.outPol : !cfg.outPol;
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            count     <= '0;
            image     <= '0;
            tcPulse   <= 1'b0;
            irq       <= 1'b0;
            outLevel  <= 1'b0;
            freezeAck <= 1'b0;
            active    <= 1'b0;
            bark      <= 1'b0;
            pend      <= 1'b0;
        end
        else
        begin
            count     <= next_count;
            image     <= next_image;
            tcPulse   <= next_tcPulse;
            irq       <= next_irq;
            outLevel  <= next_outLevel;
            freezeAck <= freeze;
            active    <= next_active;
            bark      <= next_bark;
            pend      <= next_pend;
        end
    end

    // =========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence pulseLoad_s;
        (mode == qct_pkg::MD_PULSE) && loadGo && !countWrite;
    endsequence

    countOnTick_a: assert property (
        !tick && !loadGo && !countWrite |=> $stable(count))
        else $error("count moved without tick, load or write");
    wdDown_a: assert property (
        mode == qct_pkg::MD_WATCHDOG && tick && step && !loadGo
        && !countWrite |=> count == $past(count) - 16'h0001)
        else $error("watchdog did not count down");
    frozenImage_a: assert property (
        mode == qct_pkg::MD_CAPTURE && freeze && !imageWrite
        |=> $stable(image))
        else $error("image changed while frozen");
    pulseLoad_a: assert property (
        pulseLoad_s |=> (count == $past(image)) && active)
        else $error("pulse load did not copy image");

endmodule : qct_unit

//--- verilog/qct_counter_timer.sv
// Four-channel counter/timer with shared prescaler and host registers.
// Assumes host strobes are one cycle long on the device clock; pins are
// asynchronous, logic-array inputs share the clock.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
module qct_counter_timer #(
    parameter int CH = qct_pkg::CH_COUNT
) (
    input  wire logic                        clock,
    input  wire logic                        reset,
    input  wire qct_pkg::qct_req_type        hostReq,
    output logic      [qct_pkg::DATA_W-1:0]  rdata,
    input  wire logic [CH-1:0]               pinIn,
    input  wire logic [CH-1:0]               arrayIn,
    output logic      [CH-1:0]               portOut,
    output logic      [CH-1:0]               irq,
    output logic                             watchdogOut
);
    localparam int DW = qct_pkg::DATA_W;

    qct_pkg::qct_cfg_type   cmd [CH];
    qct_pkg::qct_cfg_type   next_cmd [CH];
    qct_pkg::qct_mode_type  modes [CH];
    logic                   family;
    logic                   next_family;
    logic [DW-1:0]          delay;
    logic [DW-1:0]          next_delay;
    logic                   timerOff;
    logic                   next_timerOff;
    logic [CH-1:0]          freezeReg;
    logic [CH-1:0]          next_freezeReg;
    logic [DW-1:0]          next_rdata;
    logic [qct_pkg::PRE_W-1:0] preCount;
    logic [qct_pkg::PRE_W-1:0] next_preCount;
    logic                   tick;
    logic [CH-1:0]          pinS1;
    logic [CH-1:0]          pinS2;
    logic [CH-1:0]          pinS3;
    logic [CH-1:0]          pinLvl;
    logic [CH-1:0]          next_pinLvl;
    logic [CH-1:0]          arrPrev;
    logic [CH-1:0]          trigger;
    logic [CH-1:0]          swPulse;
    logic [CH-1:0]          imageWr;
    logic [CH-1:0]          countWr;
    logic [CH-1:0]          tcV;
    logic [CH-1:0]          irqV;
    logic [CH-1:0]          outV;
    logic [CH-1:0]          ackV;
    logic [CH-1:0]          activeV;
    logic [DW-1:0]          countV [CH];
    logic [DW-1:0]          imageV [CH];
    logic [CH-1:0]          next_portOut;
    logic                   next_watchdogOut;

    // One family for the whole group; channel 2 alone may watchdog.
    function automatic qct_pkg::qct_mode_type effMode(
        input logic [2:0] code,
        input logic       fam,
        input int         ch
    );
        effMode = qct_pkg::MD_OFF;
        if (fam)
        begin
            if (ch == 2)
            begin
                effMode = qct_pkg::MD_WATCHDOG;
            end
            else if (code == qct_pkg::MODE_EVENT)
            begin
                effMode = qct_pkg::MD_EVENT;
            end
            else if (code == qct_pkg::MODE_CAPTURE)
            begin
                effMode = qct_pkg::MD_CAPTURE;
            end
        end
        else
        begin
            case (code)
                qct_pkg::MODE_WAVE:  effMode = qct_pkg::MD_WAVE;
                qct_pkg::MODE_PULSE: effMode = qct_pkg::MD_PULSE;
                qct_pkg::MODE_WATCHDOG:
                begin
                    if (ch == 2)
                    begin
                        effMode = qct_pkg::MD_WATCHDOG;
                    end
                end
                default: effMode = qct_pkg::MD_OFF;
            endcase
        end
    endfunction : effMode

    // =========================================================
    // Host registers
    always_comb
    begin
        next_family    = family;
        next_delay     = delay;
        next_timerOff  = timerOff;
        next_freezeReg = freezeReg;
        next_rdata     = '0;
        swPulse        = '0;
        imageWr        = '0;
        countWr        = '0;
        for (int i = 0; i < CH; i++)
        begin
            next_cmd[i] = cmd[i];
        end
        if (hostReq.wr)
        begin
            for (int i = 0; i < CH; i++)
            begin
                if (hostReq.addr == qct_pkg::CMD_BASE + 5'(i))
                begin
                    next_cmd[i] = hostReq.wdata[8:0];
                end
                imageWr[i] = hostReq.addr == qct_pkg::IMAGE_BASE + 5'(i);
                countWr[i] = hostReq.addr == qct_pkg::COUNT_BASE + 5'(i);
            end
            case (hostReq.addr)
                qct_pkg::GLOBAL_OFF:
                    next_family = hostReq.wdata[qct_pkg::FAMILY_BIT];
                qct_pkg::LOADSTORE_OFF: swPulse = hostReq.wdata[CH-1:0];
                qct_pkg::FREEZE_OFF: next_freezeReg = hostReq.wdata[CH-1:0];
                qct_pkg::DELAY_OFF: next_delay = hostReq.wdata;
                qct_pkg::POWER_OFF:
                    next_timerOff = hostReq.wdata[qct_pkg::TMRCLK_BIT];
                default: next_family = family;
            endcase
        end
        if (hostReq.rd)
        begin
            for (int i = 0; i < CH; i++)
            begin
                if (hostReq.addr == qct_pkg::CMD_BASE + 5'(i))
                begin
                    next_rdata = {7'h00, cmd[i]};
                end
                if (hostReq.addr == qct_pkg::IMAGE_BASE + 5'(i))
                begin
                    next_rdata = imageV[i];
                end
                if (hostReq.addr == qct_pkg::COUNT_BASE + 5'(i))
                begin
                    next_rdata = countV[i];
                end
            end
            case (hostReq.addr)
                qct_pkg::GLOBAL_OFF: next_rdata = {15'h0000, family};
                qct_pkg::FREEZE_OFF: next_rdata = {12'h000, freezeReg};
                qct_pkg::STATUS_OFF: next_rdata = {8'h00, activeV, ackV};
                qct_pkg::DELAY_OFF:  next_rdata = delay;
                qct_pkg::POWER_OFF:  next_rdata = {8'h00, timerOff, 7'h00};
                default:             next_rdata = next_rdata;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < CH; i++)
            begin
                cmd[i] <= qct_pkg::CMD_RESET;
            end
            family    <= 1'b0;
            delay     <= qct_pkg::DELAY_RESET;
            timerOff  <= 1'b0;
            freezeReg <= '0;
            rdata     <= '0;
        end
        else
        begin
            for (int i = 0; i < CH; i++)
            begin
                cmd[i] <= next_cmd[i];
            end
            family    <= next_family;
            delay     <= next_delay;
            timerOff  <= next_timerOff;
            freezeReg <= next_freezeReg;
            rdata     <= next_rdata;
        end
    end

    // =========================================================
    // Prescaler
    // The tick never comes faster than clock/4, so a 20 MHz clock gives
    // 5 MHz at most, inside the 7 MHz the counters are built for.
    // Sleep has no input here: only the power bit stops the tick.
    assign tick = !timerOff
        && (preCount == {delay, 2'b11});

    always_comb
    begin
        next_preCount = tick ? '0 : preCount + 18'h00001;
        if (timerOff)
        begin
            next_preCount = '0;
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            preCount <= '0;
        end
        else
        begin
            preCount <= next_preCount;
        end
    end

    // =========================================================
    // Trigger inputs
    // A pin change is accepted once the second and third stages agree.
    always_comb
    begin
        for (int i = 0; i < CH; i++)
        begin
            next_pinLvl[i] = (pinS2[i] == pinS3[i]) ? pinS3[i] : pinLvl[i];
            trigger[i] = (cmd[i].srcPin && next_pinLvl[i] != pinLvl[i]
                && next_pinLvl[i] == cmd[i].inPol)
                || (cmd[i].srcArray && arrayIn[i] && !arrPrev[i]);
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            pinS1   <= '0;
            pinS2   <= '0;
            pinS3   <= '0;
            pinLvl  <= '0;
            arrPrev <= '0;
        end
        else
        begin
            pinS1   <= pinIn;
            pinS2   <= pinS1;
            pinS3   <= pinS2;
            pinLvl  <= next_pinLvl;
            arrPrev <= arrayIn;
        end
    end

    // =========================================================
    // Count units
    for (genvar g = 0; g < CH; g++)
    begin : gUnit
        assign modes[g] = effMode(cmd[g].mode, family, g);

        qct_unit #(
            .DATA_W (DW)
        ) uUnit (
            .clock      (clock),
            .reset      (reset),
            .tick       (tick),
            .mode       (modes[g]),
            .cfg        (cmd[g]),
            .trigger    (trigger[g]),
            .swStrobe   (swPulse[g]),
            .handIn     (tcV[g ^ 1]),
            .freeze     (freezeReg[g]),
            .imageWrite (imageWr[g]),
            .countWrite (countWr[g]),
            .wdata      (hostReq.wdata),
            .count      (countV[g]),
            .image      (imageV[g]),
            .tcPulse    (tcV[g]),
            .irq        (irqV[g]),
            .outLevel   (outV[g]),
            .freezeAck  (ackV[g]),
            .active     (activeV[g])
        );
    end

    // =========================================================
    // Outputs
    // In waveform the even unit drives the pair's pin for both slots.
    always_comb
    begin
        next_portOut = outV;
        for (int i = 0; i < CH; i += 2)
        begin
            if (modes[i] == qct_pkg::MD_WAVE)
            begin
                next_portOut[i + 1] = outV[i];
            end
        end
        next_watchdogOut = (modes[2] == qct_pkg::MD_WATCHDOG)
            && (outV[2] == cmd[2].outPol);
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            portOut     <= '0;
            irq         <= '0;
            watchdogOut <= 1'b0;
        end
        else
        begin
            portOut     <= next_portOut;
            irq         <= irqV;
            watchdogOut <= next_watchdogOut;
        end
    end

    // =========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    tickGap_a: assert property (tick |=> !tick [*3])
        else $error("prescaler tick faster than clock/4");
    clockOff_a: assert property (
        $past(timerOff) && timerOff |-> !tick && preCount == '0)
        else $error("tick while timer clock disabled");
    wdOnly2_a: assert property (
        modes[0] != qct_pkg::MD_WATCHDOG && modes[1] != qct_pkg::MD_WATCHDOG
        && modes[3] != qct_pkg::MD_WATCHDOG)
        else $error("watchdog on a channel other than 2");
    familyMix_a: assert property (
        family |-> modes[2] == qct_pkg::MD_WATCHDOG
        && modes[0] != qct_pkg::MD_WAVE && modes[0] != qct_pkg::MD_PULSE)
        else $error("families mixed");
    ackFollow_a: assert property (
        hostReq.wr && hostReq.addr == qct_pkg::FREEZE_OFF
        |=> ##1 ackV == $past(hostReq.wdata[CH-1:0], 2))
        else $error("freeze acknowledge late or wrong");
    readZero_a: assert property (
        hostReq.rd && hostReq.addr > qct_pkg::POWER_OFF |=> rdata == '0)
        else $error("unmapped read not zero");

endmodule : qct_counter_timer

//--- bench/qct_host_model.sv
// Host side of the register port: one-cycle write and read strobes.
// Assumes the caller runs on the same clock; rdata stands one cycle.
`timescale 1ns/1ps
module qct_host_model (
    input  wire logic                 clock,
    output qct_pkg::qct_req_type      hostReq,
    input  wire logic [15:0]          rdata
);
    initial hostReq = '0;
    task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock);
        hostReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        hostReq <= '0;
    endtask : write_reg
    task automatic read_reg(input logic [4:0] a, output logic [15:0] d);
        @(posedge clock);
        hostReq <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clock);
        hostReq <= '0;
        #1 d = rdata;
    endtask : read_reg
endmodule : qct_host_model

//--- bench/quad_counter_timer_unit_tb.sv
// Self-checking bench of the four-channel counter/timer.
// Assumes a 20 MHz clock, well under the 30 MHz input limit.
`timescale 1ns/1ps
module quad_counter_timer_unit_tb;
    logic clock = 0, reset = 1;
    logic [3:0] pinIn = 4'h0, arrayIn = 4'h0, portOut, irq;
    logic watchdogOut;
    logic [15:0] rdata, v;
    qct_pkg::qct_req_type hostReq;
    int errors = 0, compares = 0, n;
    qct_counter_timer uut (.clock(clock), .reset(reset),
        .hostReq(hostReq), .rdata(rdata), .pinIn(pinIn),
        .arrayIn(arrayIn), .portOut(portOut), .irq(irq),
        .watchdogOut(watchdogOut));
    qct_host_model host (.clock(clock), .hostReq(hostReq), .rdata(rdata));
    // =========================================================
    // Helpers
    initial forever #25 clock = ~clock;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop
    // Counts cycles until the channel raises its interrupt, 79 at most.
    task automatic wait_irq(input int ch);
        for (n = 1; n < 80; n++)
        begin
            @(posedge clock);
            #1;
            if (irq[ch] === 1'b1)
                break;
        end
    endtask : wait_irq
    // =========================================================
    // Scenarios
    task automatic test_reset;
        for (int a = 0; a < 20; a++)
        begin
            host.read_reg(a[4:0], v);
            check(v, 16'h0000);
        end
        host.write_reg(5'h13, 16'hFFFF);
        host.read_reg(5'h13, v);
        check(v, 16'h0000);
        $display("test_reset done");
    endtask : test_reset
    task automatic test_pulse;
        host.write_reg(5'h04, 16'h0003);
        host.write_reg(5'h00, 16'h0101);
        host.write_reg(5'h0D, 16'h0001);
        host.read_reg(5'h08, v);
        check(v, 16'h0003);
        check({15'h0, portOut[0]}, 16'h0000);
        wait_irq(0);
        check(16'(n >= 8 && n <= 20), 16'h0001);
        host.read_reg(5'h08, v);
        check(v, 16'hFFFF);
        check({15'h0, portOut[0]}, 16'h0001);
        $display("test_pulse done");
    endtask : test_pulse
    task automatic test_timer_off;
        host.write_reg(5'h11, 16'h0080);
        host.write_reg(5'h0D, 16'h0001);
        repeat (40) @(posedge clock);
        host.read_reg(5'h08, v);
        check(v, 16'h0003);
        host.write_reg(5'h10, 16'h0001);
        host.write_reg(5'h11, 16'h0000);
        wait_irq(0);
        check(16'(n >= 22 && n <= 40), 16'h0001);
        $display("test_timer_off done");
    endtask : test_timer_off
    task automatic test_array;
        host.write_reg(5'h05, 16'h0002);
        host.write_reg(5'h01, 16'h0181);
        @(posedge clock);
        arrayIn <= 4'h2;
        @(posedge clock);
        arrayIn <= 4'h0;
        wait_irq(1);
        check(16'(n < 40), 16'h0001);
        host.read_reg(5'h05, v);
        check(v, 16'h0002);
        $display("test_array done");
    endtask : test_array
    task automatic test_freeze;
        host.write_reg(5'h0E, 16'h000F);
        repeat (3) @(posedge clock);
        host.read_reg(5'h0F, v);
        check(v, 16'h000F);
        check({15'h0, watchdogOut}, 16'h0000);
        $display("test_freeze done");
    endtask : test_freeze
    // Event/capture family: pin capture, frozen store, event count and the
    // forced down-counting watchdog on channel 2.
    task automatic test_family;
        logic [15:0] w;
        host.write_reg(5'h0E, 16'h0000);
        host.write_reg(5'h0C, 16'h0001);
        host.write_reg(5'h03, 16'h0173);
        repeat (16) @(posedge clock);
        pinIn <= 4'h8;
        wait_irq(3);
        check(16'(n < 8), 16'h0001);
        host.read_reg(5'h07, v);
        repeat (8) @(posedge clock);
        host.read_reg(5'h0B, w);
        check(16'(v != 16'h0000 && w > v), 16'h0001);
        host.write_reg(5'h0E, 16'h0008);
        host.write_reg(5'h0D, 16'h0008);
        host.read_reg(5'h07, w);
        check(w, v);
        host.write_reg(5'h08, 16'h0000);
        host.write_reg(5'h00, 16'h01A2);
        @(posedge clock);
        arrayIn <= 4'h1;
        @(posedge clock);
        arrayIn <= 4'h0;
        repeat (10) @(posedge clock);
        host.read_reg(5'h04, w);
        check(w, 16'h0001);
        host.write_reg(5'h06, 16'h0001);
        host.write_reg(5'h02, 16'h0120);
        host.write_reg(5'h0D, 16'h0004);
        wait_irq(2);
        check({15'h0, watchdogOut}, 16'h0001);
        host.read_reg(5'h0A, w);
        check(w, 16'hFFFF);
        $display("test_family done");
    endtask : test_family
    // =========================================================
    // Main sequence and watchdog
    initial
    begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        test_reset();
        test_pulse();
        test_timer_off();
        test_array();
        test_freeze();
        test_family();
        report_and_stop();
    end
    initial
    begin
        #1000000;
        errors++;
        report_and_stop();
    end
endmodule : quad_counter_timer_unit_tb
